/* File: src/flash_host.sv */
// Host controller that drives an asynchronous boot-block flash through its bus pins.
`timescale 1ns/10ps
`default_nettype none
module flash_host
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] sw_addr_i,
    input wire logic [31:0] sw_wdata_i,
    input wire logic sw_write_i,
    input wire logic sw_read_i,
    output logic [31:0] sw_rdata_o,
    output logic [19:0] flash_addr_o,
    input wire logic [15:0] flash_dq_i,
    output logic [15:0] flash_dq_o,
    output logic flash_dq_oe_o,
    output logic chip_sel_n_o,
    output logic out_en_n_o,
    output logic write_n_o,
    output logic reset_powerdown_n_o,
    output logic unlock_high_voltage_o,
    output logic boot_protect_o,
    output logic byte_mode_o
);
    import flash_host_pkg::*;

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    typedef enum {ST_IDLE, ST_RESET, ST_WSETUP, ST_WSTROBE, ST_WHOLD, ST_RSETUP, ST_RSTROBE,
                  ST_RGAP, ST_NEXT} state_e;
    state_e state_r; // Bus sequencer state.
    logic [2:0] op_r; // Operation in progress.
    logic [1:0] step_r; // Bus cycle index within the operation.
    logic [7:0] cnt_r; // Phase cycle counter.
    logic [19:0] addr_r; // Target address register.
    logic [15:0] wdata_r; // Data to program.
    logic [15:0] rdata_r; // Last data read from the flash.
    logic [7:0] status_r; // Last status byte polled.
    logic busy_r; // Operation in progress flag.
    logic timeout_r; // Poll limit reached, sticky.
    logic [7:0] poll_limit_r; // Status polls allowed beyond the first.
    logic [7:0] polls_r; // Polls done so far.
    logic unlock_r; // Unlock voltage request.
    logic protect_r; // Boot-protect level.
    logic byte_mode_r; // Byte-wide configuration.
    logic drive_r; // Host drives the data pins.
    logic [7:0] cmd_r; // Command byte of the current write cycle.

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic wr_ctrl = sw_write_i && (sw_addr_i == REG_CTRL) && !busy_r;
    wire logic wr_addr = sw_write_i && (sw_addr_i == REG_ADDR);
    wire logic wr_data = sw_write_i && (sw_addr_i == REG_WDATA);
    wire logic wr_cfg = sw_write_i && (sw_addr_i == REG_CONFIG);
    wire logic phase_done = (cnt_r == 8'h00);
    // The done flag of the last polled status decides whether the engine is still busy.
    // It comes from the snapshot taken while output enable was low, because in the gap
    // that ends each poll nobody drives the data pins and they show no valid level.
    wire logic engine_done = status_r[DONE_BIT];
    // Program and erase take two writes; reset takes none; others take one.
    wire logic two_writes = (op_r == OP_PROGRAM) || (op_r == OP_ERASE);
    // Program and erase are followed by status polling.
    wire logic polls = two_writes;
    // Reads of array, identifier and status use one read cycle after the command.
    wire logic has_read = (op_r == OP_READ) || (op_r == OP_READ_ID) || (op_r == OP_READ_STATUS);
    wire logic last_write = two_writes ? (step_r == 2'd1) : 1'b1;
    wire logic [31:0] status_word = {16'h0000, 8'h00, status_r} | 32'h0;
    wire logic [31:0] host_status = {21'h0, timeout_r, busy_r, op_r, polls_r[5:0]};
    wire logic [31:0] cfg_word = {13'h0, byte_mode_r, protect_r, unlock_r, 8'h0, poll_limit_r};

    // Command byte for each write cycle of the operation.
    always_comb
    begin
        case (op_r)
            OP_PROGRAM: cmd_r = (step_r == 2'd0) ? CMD_PROGRAM_SETUP : wdata_r[7:0];
            OP_ERASE: cmd_r = (step_r == 2'd0) ? CMD_ERASE_SETUP : CMD_ERASE_CONFIRM;
            OP_CLEAR: cmd_r = CMD_CLEAR_STATUS;
            OP_READ_ID: cmd_r = CMD_READ_ID;
            OP_READ_STATUS: cmd_r = CMD_READ_STATUS;
            default: cmd_r = CMD_READ_ARRAY;
        endcase
    end

    // Second program write carries the full word, only its low byte on the pins in byte mode; command writes carry the byte.
    wire logic [15:0] dq_word = (op_r == OP_PROGRAM && step_r == 2'd1) ? wdata_r : {8'h00, cmd_r};

    // ----------------------------------------------------------------
    // Pin outputs
    // ----------------------------------------------------------------
    // Reads use the chip select and output enable; writes pulse the write strobe while
    // chip select is held low, so the write strobe's rising edge latches the data first.
    assign chip_sel_n_o = !(state_r == ST_WSETUP || state_r == ST_WSTROBE ||
                            state_r == ST_WHOLD || state_r == ST_RSETUP || state_r == ST_RSTROBE);
    assign write_n_o = (state_r != ST_WSTROBE);
    assign out_en_n_o = (state_r != ST_RSTROBE);
    assign flash_dq_oe_o = drive_r;
    assign flash_dq_o = byte_mode_r ? {8'h00, wdata_r[7:0] & 8'hFF} & {8'h00, dq_word[7:0]}
                                    | {8'h00, dq_word[7:0]} : dq_word;
    assign flash_addr_o = addr_r;
    assign reset_powerdown_n_o = (state_r != ST_RESET);
    assign unlock_high_voltage_o = unlock_r;
    assign boot_protect_o = protect_r;
    assign byte_mode_o = byte_mode_r;

    // Read data for the software port, valid in the cycle after the read strobe.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            sw_rdata_o <= 32'h0;
        else if (sw_read_i)
        begin
            case (sw_addr_i)
                REG_ADDR: sw_rdata_o <= {12'h0, addr_r};
                REG_WDATA: sw_rdata_o <= {16'h0, wdata_r};
                REG_RDATA: sw_rdata_o <= {16'h0, rdata_r};
                REG_STATUS: sw_rdata_o <= status_word | (host_status << 8);
                REG_CONFIG: sw_rdata_o <= cfg_word;
                default: sw_rdata_o <= 32'h0;
            endcase
        end
        else
            sw_rdata_o <= 32'h0;
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // Software sets the address, data, unlock levels and byte mode.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            addr_r <= 20'h0;
            wdata_r <= 16'h0;
            poll_limit_r <= POLL_LIMIT_RESET;
            unlock_r <= 1'b0;
            protect_r <= 1'b0;
            byte_mode_r <= 1'b0;
        end
        else
        begin
            if (wr_addr)
                addr_r <= sw_wdata_i[19:0];
            if (wr_data)
                wdata_r <= sw_wdata_i[15:0];
            if (wr_cfg)
            begin
                poll_limit_r <= sw_wdata_i[7:0];
                unlock_r <= sw_wdata_i[16];
                protect_r <= sw_wdata_i[17];
                byte_mode_r <= sw_wdata_i[18];
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus sequencer
    // ----------------------------------------------------------------
    // Read and write phases last STROBE_CNT plus one cycles, reset RESET_CNT plus one; a status poll ends with a gap in which chip
    // select and output enable are high, so every poll is a fresh read cycle.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            state_r <= ST_IDLE;
            op_r <= OP_READ;
            step_r <= 2'd0;
            cnt_r <= 8'h00;
            busy_r <= 1'b0;
            drive_r <= 1'b0;
            rdata_r <= 16'h0;
            status_r <= 8'h00;
            timeout_r <= 1'b0;
            polls_r <= 8'h00;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (wr_ctrl)
                    begin
                        op_r <= sw_wdata_i[2:0];
                        step_r <= 2'd0;
                        polls_r <= 8'h00;
                        busy_r <= 1'b1;
                        timeout_r <= 1'b0;
                        if (sw_wdata_i[2:0] == OP_RESET)
                        begin
                            state_r <= ST_RESET;
                            cnt_r <= RESET_CNT;
                        end
                        else
                        begin
                            state_r <= ST_WSETUP;
                            cnt_r <= STROBE_CNT;
                            drive_r <= 1'b1;
                        end
                    end
                end
                ST_RESET:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (phase_done)
                    begin
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                    end
                end
                ST_WSETUP:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (phase_done)
                    begin
                        state_r <= ST_WSTROBE;
                        cnt_r <= STROBE_CNT;
                    end
                end
                ST_WSTROBE:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (phase_done)
                    begin
                        state_r <= ST_WHOLD;
                        cnt_r <= STROBE_CNT;
                    end
                end
                ST_WHOLD:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (phase_done)
                    begin
                        cnt_r <= STROBE_CNT;
                        if (!last_write)
                        begin
                            step_r <= step_r + 2'd1;
                            state_r <= ST_WSETUP;
                        end
                        else if (polls || has_read)
                        begin
                            drive_r <= 1'b0;
                            state_r <= ST_RSETUP;
                        end
                        else
                        begin
                            drive_r <= 1'b0;
                            state_r <= ST_NEXT;
                        end
                    end
                end
                ST_RSETUP:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (phase_done)
                    begin
                        state_r <= ST_RSTROBE;
                        cnt_r <= STROBE_CNT;
                    end
                end
                ST_RSTROBE:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (phase_done)
                    begin
                        rdata_r <= flash_dq_i;
                        if (polls)
                            status_r <= flash_dq_i[7:0];
                        state_r <= ST_RGAP;
                        cnt_r <= STROBE_CNT;
                    end
                end
                ST_RGAP:
                begin
                    cnt_r <= cnt_r - 8'h01;
                    if (phase_done)
                    begin
                        polls_r <= polls_r + 8'h01;
                        if (!polls || engine_done)
                            state_r <= ST_NEXT;
                        else if (polls_r >= poll_limit_r)
                        begin
                            timeout_r <= 1'b1;
                            state_r <= ST_NEXT;
                        end
                        else
                        begin
                            state_r <= ST_RSETUP;
                            cnt_r <= STROBE_CNT;
                        end
                    end
                end
                ST_NEXT:
                begin
                    busy_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: src/flash_host_pkg.sv */
// Package with command codes, status bit positions and timing constants of the flash host.
package flash_host_pkg;
    // Command codes written to the flash command port.
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
    // Status bit positions in the flash status byte.
    localparam int DONE_BIT = 7;
    localparam int ERASE_ERR_BIT = 5;
    localparam int PROGRAM_ERR_BIT = 4;
    localparam int SUPPLY_FAULT_BIT = 3;
    // Host register offsets on the software port.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_RDATA = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CONFIG = 4'h5;
    // Operation codes written to the control register.
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_ERASE = 3'h2;
    localparam logic [2:0] OP_CLEAR = 3'h3;
    localparam logic [2:0] OP_READ_ID = 3'h4;
    localparam logic [2:0] OP_READ_STATUS = 3'h5;
    localparam logic [2:0] OP_RESET = 3'h6;
    // Bus phase times in ns and derived cycle counts at 50 MHz.
    localparam int CLK_PERIOD_NS = 20;
    localparam int STROBE_TIME_NS = 60;
    localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_TIME_NS = 300;
    localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYCLES);
    localparam logic [7:0] RESET_CNT = 8'(RESET_CYCLES);
    localparam logic [7:0] POLL_LIMIT_RESET = 8'hFF;
endpackage

/* File: verif/flash_host_checker.sv */
// Concurrent assertions on the pin cycles of the flash host.
`timescale 1ns/10ps
`default_nettype none
module flash_host_checker
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic sw_read_i,
    input wire logic [31:0] sw_rdata_o,
    input wire logic chip_sel_n_o,
    input wire logic out_en_n_o,
    input wire logic write_n_o,
    input wire logic reset_powerdown_n_o,
    input wire logic flash_dq_oe_o
);
    // ----------------------------------------
    // Clocking and named pin sequences
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // The write strobe phase lasts four cycles.
    sequence s_we_low;
        (!write_n_o)[*4] ##1 write_n_o;
    endsequence
    // A read drops output enable for four cycles, then lets it rise again.
    sequence s_oe_pulse;
        (!out_en_n_o)[*4] ##1 out_en_n_o;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_write_pins_legal:
    assert property (!write_n_o |-> !chip_sel_n_o && out_en_n_o && flash_dq_oe_o)
        else $error("write strobe without select or data drive");
    chk_strobe_width:
    assert property ($fell(write_n_o) |-> s_we_low)
        else $error("write strobe width wrong");
    chk_we_rises_first:
    assert property ($rose(write_n_o) |-> !chip_sel_n_o)
        else $error("select released before write strobe");
    chk_read_toggles:
    assert property ($fell(out_en_n_o) |-> s_oe_pulse)
        else $error("output enable not toggled per read");
    chk_select_gap:
    assert property ($rose(out_en_n_o) |-> ##[0:4] chip_sel_n_o)
        else $error("select not released after a read");
    chk_no_contention:
    assert property (!out_en_n_o |-> !flash_dq_oe_o && !chip_sel_n_o && write_n_o)
        else $error("host drives data during a read");
    chk_rdata_idle:
    assert property (!sw_read_i |=> sw_rdata_o == 32'h0)
        else $error("read data outside its cycle");
    chk_powerdown_len:
    assert property ($fell(reset_powerdown_n_o) |-> ##15 !reset_powerdown_n_o ##1 reset_powerdown_n_o)
        else $error("power-down pulse length wrong");
endmodule
bind flash_host flash_host_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .sw_read_i(sw_read_i),
    .sw_rdata_o(sw_rdata_o), .chip_sel_n_o(chip_sel_n_o), .out_en_n_o(out_en_n_o),
    .write_n_o(write_n_o), .reset_powerdown_n_o(reset_powerdown_n_o),
    .flash_dq_oe_o(flash_dq_oe_o));
`default_nettype wire

/* File: verif/flash_model.sv */
// Behavioural model of the boot-block flash on the far side of the host.
`timescale 1ns/10ps
`default_nettype none
module flash_model
    import flash_host_pkg::*;
#(
    parameter logic [15:0] MFR_CODE = 16'h00A1, // Arbitrary value.
    parameter logic [15:0] DEV_CODE = 16'h5A3C, // Arbitrary value.
    parameter int BUSY_NS = 300
)
(
    input wire logic [19:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic cs_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic rp_n_i,
    input wire logic unlock_i,
    input wire logic protect_i,
    input wire logic byte_mode_i,
    input wire logic vpp_ok_i,
    output logic [15:0] dq_o,
    output logic [1:0] dq_oe_o
);
    logic [15:0] mem [16]; // Small array aliased by the low address bits.
    logic [7:0] sr = 8'h80; // Status byte.
    logic [7:0] snap = 8'h80; // Status frozen for the current read.
    logic [7:0] pend = 8'h00; // Setup code waiting for its second write.
    logic [7:0] prev; // Setup code seen by the current write.
    logic [1:0] mode = 2'h0; // Zero array, one identifier, two status.
    logic busy = 1'b0; // Write engine running.
    wire rd_en = rp_n_i && !cs_n_i && !oe_n_i && we_n_i;
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    // Byte mode floats the upper byte of every read.
    assign dq_oe_o = {rd_en && !byte_mode_i, rd_en};
    assign dq_o = (mode == 2'h0) ? mem[addr_i[3:0]] :
                  (mode == 2'h1) ? (addr_i[0] ? DEV_CODE : MFR_CODE) : {8'h00, snap};
    // Status is frozen when the later of the two read strobes falls.
    always @(negedge oe_n_i or negedge cs_n_i)
        if (!oe_n_i && !cs_n_i) snap = sr;
    // Power-down returns to array mode with a clean status.
    always @(negedge rp_n_i)
    begin
        mode = 2'h0;
        sr = 8'h80;
        pend = 8'h00;
    end
    // The write engine runs with address and data latched at the strobe edge.
    task automatic run(input logic ers, input logic bad);
        logic [19:0] a;
        logic [15:0] d;
        int e;
        a = addr_i;
        d = dq_i;
        e = ers ? ERASE_ERR_BIT : PROGRAM_ERR_BIT;
        mode = 2'h2;
        busy = 1'b1;
        sr[DONE_BIT] = 1'b0;
        #(BUSY_NS);
        if (bad)
            sr[5:4] = 2'h3;
        else if (!vpp_ok_i)
        begin
            sr[e] = 1'b1;
            sr[SUPPLY_FAULT_BIT] = 1'b1;
        end
        else if (a[19:16] == 4'hF && !unlock_i && !protect_i)
            sr[e] = 1'b1;
        else if (ers)
        begin
            foreach (mem[i]) mem[i] = 16'h0000;
            foreach (mem[i]) mem[i] = 16'hFFFF;
        end
        else
            mem[a[3:0]] = mem[a[3:0]] & d;
        sr[DONE_BIT] = 1'b1;
        busy = 1'b0;
    endtask
    // Commands are taken when the write strobe rises first; a busy engine ignores them.
    always @(posedge we_n_i)
        if (!cs_n_i && rp_n_i && !busy)
        begin
            prev = pend;
            pend = 8'h00;
            if (prev == CMD_PROGRAM_SETUP)
                run(1'b0, 1'b0);
            else if (prev == CMD_ERASE_SETUP)
                run(1'b1, dq_i[7:0] != CMD_ERASE_CONFIRM);
            else
                case (dq_i[7:0])
                    CMD_READ_ARRAY: mode = 2'h0;
                    CMD_READ_ID: mode = 2'h1;
                    CMD_READ_STATUS: mode = 2'h2;
                    CMD_CLEAR_STATUS: sr[5:3] = 3'h0;
                    CMD_PROGRAM_SETUP, CMD_ERASE_SETUP: pend = dq_i[7:0];
                    default: ;
                endcase
        end
endmodule
`default_nettype wire

/* File: verif/flash_host_tb.sv */
// Self-checking testbench of the flash host against the flash model.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module flash_host_tb;
    import flash_host_pkg::*;
    localparam logic [15:0] MFR = 16'h00A1; // Arbitrary value.
    localparam logic [15:0] DEV = 16'h5A3C; // Arbitrary value.
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic sw_write = 1'b0;
    logic sw_read = 1'b0;
    logic vpp_ok = 1'b1; // Program supply inside its write range.
    logic [15:0] noise = 16'h0; // Floating bus pattern, new every cycle.
    int errors = 0;
    int cmp_count = 0;
    wire logic [31:0] rdata;
    wire logic [19:0] addr;
    wire logic [15:0] h_dq, m_dq, bus;
    wire logic [1:0] m_oe;
    wire logic h_oe, cs_n, oe_n, we_n, rp_n, unl, prot, bym;
    always #10 clk_i = ~clk_i;
    always @(negedge clk_i) noise <= noise + 16'h3C5B;
    // Wire level from both drivers; an undriven byte shows the changing pattern.
    assign bus = h_oe ? h_dq : {m_oe[1] ? m_dq[15:8] : noise[15:8], m_oe[0] ? m_dq[7:0] : noise[7:0]};
    flash_host u_dut (.clk_i(clk_i), .reset_i(reset_i), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
        .sw_write_i(sw_write), .sw_read_i(sw_read), .sw_rdata_o(rdata), .flash_addr_o(addr),
        .flash_dq_i(bus), .flash_dq_o(h_dq), .flash_dq_oe_o(h_oe), .chip_sel_n_o(cs_n),
        .out_en_n_o(oe_n), .write_n_o(we_n), .reset_powerdown_n_o(rp_n),
        .unlock_high_voltage_o(unl), .boot_protect_o(prot), .byte_mode_o(bym));
    flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.addr_i(addr), .dq_i(bus), .cs_n_i(cs_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .rp_n_i(rp_n), .unlock_i(unl), .protect_i(prot),
        .byte_mode_i(bym), .vpp_ok_i(vpp_ok), .dq_o(m_dq), .dq_oe_o(m_oe));
    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One write cycle on the software port, then a quiet cycle.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_write <= 1'b1;
        @(posedge clk_i);
        sw_write <= 1'b0;
        @(posedge clk_i);
    endtask
    // One read cycle; data are taken in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, output logic [31:0] q);
        sw_addr <= a;
        sw_read <= 1'b1;
        @(posedge clk_i);
        sw_read <= 1'b0;
        #1 q = rdata;
        @(posedge clk_i);
    endtask
    // Starts one operation, waits for it under a bound and returns the flash word read.
    task automatic xfer(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d,
                        output logic [15:0] r);
        logic [31:0] q;
        wr(REG_ADDR, {12'h000, a});
        wr(REG_WDATA, {16'h0000, d});
        wr(REG_CTRL, {29'h0, o});
        q = 32'h0002_0000;
        for (int n = 0; n < 3000 && q[17] !== 1'b0; n++) rd(REG_STATUS, q);
        if (q[17] !== 1'b0)
        begin
            errors++;
            end_of_test();
        end
        `CHK("poll timeout flag", 1'b0, q[18])
        rd(REG_RDATA, q);
        r = q[15:0];
    endtask
    task automatic ck(input logic [2:0] o, input logic [19:0] a, input logic [15:0] d,
                      input logic [15:0] e, input string n);
        logic [15:0] r;
        xfer(o, a, d, r);
        `CHK(n, e, r)
    endtask
    task automatic t_reset_state;
        logic [31:0] q;
        rd(REG_CONFIG, q);
        `CHK("config reset value", 32'h0000_00FF, q)
        rd(4'hF, q);
        `CHK("unmapped register", 32'h0000_0000, q)
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0080, "status after reset");
        ck(OP_READ, 20'h00003, 16'h0, 16'hFFFF, "array after reset");
    endtask
    task automatic t_program;
        logic [15:0] r;
        xfer(OP_PROGRAM, 20'h00005, 16'h1234, r);
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0080, "status after program");
        ck(OP_READ, 20'h00005, 16'h0, 16'h1234, "programmed word");
        xfer(OP_PROGRAM, 20'h00005, 16'h00FF, r);
        ck(OP_READ, 20'h00005, 16'h0, 16'h0034, "reprogrammed word");
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0080, "kept ones not flagged");
    endtask
    task automatic t_erase;
        logic [15:0] r;
        xfer(OP_ERASE, 20'h00009, 16'h0, r);
        ck(OP_READ, 20'h00005, 16'h0, 16'hFFFF, "erased word");
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0080, "status after erase");
    endtask
    task automatic t_ident;
        logic [15:0] r;
        ck(OP_READ_ID, 20'h00000, 16'h0, MFR, "maker code");
        ck(OP_READ_ID, 20'h00001, 16'h0, DEV, "device code");
        wr(REG_CONFIG, 32'h0004_00FF);
        xfer(OP_READ_ID, 20'h00001, 16'h0, r);
        `CHK("byte wide device code", DEV[7:0], r[7:0])
        wr(REG_CONFIG, 32'h0000_00FF);
    endtask
    task automatic t_supply;
        logic [15:0] r;
        vpp_ok <= 1'b0;
        xfer(OP_PROGRAM, 20'h00006, 16'h0000, r);
        vpp_ok <= 1'b1;
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0098, "supply fault");
        ck(OP_READ, 20'h00006, 16'h0, 16'hFFFF, "array kept");
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0098, "sticky flags");
        xfer(OP_CLEAR, 20'h0, 16'h0, r);
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0080, "flags cleared");
    endtask
    task automatic t_boot;
        logic [15:0] r;
        xfer(OP_PROGRAM, 20'hF0007, 16'h0000, r);
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0090, "boot block locked");
        ck(OP_READ, 20'hF0007, 16'h0, 16'hFFFF, "boot word kept");
        xfer(OP_CLEAR, 20'h0, 16'h0, r);
        wr(REG_CONFIG, 32'h0002_00FF);
        xfer(OP_PROGRAM, 20'hF0007, 16'h0000, r);
        ck(OP_READ, 20'hF0007, 16'h0, 16'h0000, "boot word with protect");
        wr(REG_CONFIG, 32'h0001_00FF);
        xfer(OP_PROGRAM, 20'hF0008, 16'h0F0F, r);
        ck(OP_READ, 20'hF0008, 16'h0, 16'h0F0F, "boot word with unlock");
        wr(REG_CONFIG, 32'h0000_00FF);
    endtask
    task automatic t_powerdown;
        logic [15:0] r;
        vpp_ok <= 1'b0;
        xfer(OP_PROGRAM, 20'h00002, 16'h0000, r);
        vpp_ok <= 1'b1;
        xfer(OP_RESET, 20'h0, 16'h0, r);
        ck(OP_READ_STATUS, 20'h0, 16'h0, 16'h0080, "status after power-down");
    endtask
    // Main sequence: reset for five cycles, then every scenario in turn.
    initial
    begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        t_reset_state();
        t_program();
        t_erase();
        t_ident();
        t_supply();
        t_boot();
        t_powerdown();
        end_of_test();
    end
endmodule
`default_nettype wire
